//--- rtl/slp_defs.svh
// slp_defs.svh: register offsets, field positions, reset values and timing counts
// for the sleep and clock gating controller; definitions only.
`ifndef SLP_DEFS_SVH
`define SLP_DEFS_SVH

`define SLP_ADDR_W 4
`define SLP_OFF_MCU_CTRL 4'h0
`define SLP_OFF_PERIPH_STOP 4'h4
`define SLP_OFF_CMP_CTRL 4'h8
`define SLP_OFF_STATUS 4'hC

// control register fields
`define SLP_ARM_BIT 5
`define SLP_KIND_HI 4
`define SLP_KIND_LO 3
`define SLP_ISC0_HI 1
`define SLP_ISC0_LO 0
`define SLP_CTRL_WMASK 8'h7B
`define SLP_CTRL_RESET 8'h00
`define SLP_STOP_WMASK 8'h0F
`define SLP_STOP_RESET 8'h00
`define SLP_CMP_OFF_BIT 7
`define SLP_CMP_REF_BIT 6
`define SLP_CMP_WMASK 8'hC0
`define SLP_CMP_RESET 8'h00

// peripheral stop bit positions
`define SLP_STOP_CONV 0
`define SLP_STOP_SER 1
`define SLP_STOP_TMR0 2
`define SLP_STOP_TMR1 3

// wake timing, in core cycles
`define SLP_HALT_CYCLES 4'h4
`define SLP_STANDBY_WAKE_CYCLES 4'h6

`endif

//--- rtl/slp_pkg.sv
// slp_pkg: types shared by the sleep controller and its testbench.
// assumes slp_defs.svh supplies the numeric constants.
package slp_pkg;

    typedef enum logic [1:0] {
        SLP_KIND_IDLE = 2'b00,
        SLP_KIND_NOISE = 2'b01,
        SLP_KIND_PDOWN = 2'b10,
        SLP_KIND_STBY = 2'b11
    } slp_kind_e;

    typedef enum logic [2:0] {
        SLP_ST_RUN = 3'b000,
        SLP_ST_SLEEP = 3'b001,
        SLP_ST_START = 3'b010,
        SLP_ST_HALT = 3'b011,
        SLP_ST_RESUME = 3'b100
    } slp_state_e;

    // clock enables leaving the controller
    typedef struct packed {
        logic core;
        logic flash;
        logic io;
        logic conv;
        logic fast;
        logic osc;
    } slp_clk_s;

    // wake sources presented by the rest of the chip
    typedef struct packed {
        logic conv_done;
        logic store_ready;
        logic ext_zero;
        logic ext_one;
        logic pin_change;
        logic watchdog;
        logic serial;
        logic other_io;
    } slp_wake_s;

    typedef struct packed {
        logic rst_ext;
        logic rst_wdt;
        logic rst_bod;
    } slp_rst_s;

endpackage : slp_pkg

//--- rtl/slp_retain_mem.sv
// slp_retain_mem: small retention store for the working registers.
// assumes one clock; contents are never touched by sleep entry or exit.
`timescale 1ns/1ps
module slp_retain_mem #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 8
) (
    input wire logic clk_i, // system clock
    input wire logic we_i, // write strobe
    input wire logic [$clog2(DEPTH)-1:0] addr_i, // word address
    input wire logic [WIDTH-1:0] wdata_i, // write data
    output logic [WIDTH-1:0] rdata_o // registered read data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // no reset on the array: contents survive every sleep cycle
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : slp_retain_mem

//--- rtl/slp_ctrl.sv
// slp_ctrl: sleep mode controller with clock gating and peripheral stop.
// assumes a classic wishbone master, a core that pulses sleep_exec_i, and
// asynchronous wake logic that reaches this block as synchronous levels.
//
// Function
// R1 - sleep entered only when sleep instruction executes with arm bit set
// R2 - mode 00 idle: stop core and flash clocks, others run
// R3 - mode 01 noise reduction: stop io, core, flash; converter and oscillator run
// R4 - noise reduction wakes on converter, resets, store ready, level ext0, pin change
// R5 - mode 10 power-down: stop oscillator and all generated clocks
// R6 - power-down wakes on resets, level ext0, pin change only; code also wakes on level ext1
// R7 - mode 11 with crystal: standby, like power-down but oscillator runs
// R8 - standby wake resumes core clock within six cycles
// R9 - interrupt wake holds core four cycles after start-up, then resumes
// R10 - register file and sram contents unchanged by sleep
// R11 - reset during sleep exits to reset vector
// R12 - converter enabled: idle or noise entry starts a conversion
// R13 - outside idle only level ext0 and ext1 may wake
// R14 - idle wakes on any enabled interrupt
// R15 - waking agent holds level long enough to be detected
// R16 - stop bit gates peripheral clock, freezes state, blocks register access
// R17 - clearing stop bit resumes peripheral from held state
// R18 - stop bits matter in active and idle; deeper modes already gated
// R19 - power-down and standby force comparator off
// R20 - reference enabled when brown-out, comparator or converter needs it
// R21 - converter restart forces an extended next conversion
// R22 - fuse-enabled brown-out stays on in all sleep modes
// R23 - sleep instruction with arm clear is a no-operation
`timescale 1ns/1ps
`include "slp_defs.svh"
module slp_ctrl #(
    parameter int START_CYCLES = 16, // oscillator start-up after power-down
    parameter int NPERIPH = 4
) (
    input wire logic clk_i, // system clock, 250 MHz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic [31:0] wb_adr_i, // wishbone address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic wb_we_i, // wishbone write
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic sleep_exec_i, // core executes sleep instruction
    input wire slp_pkg::slp_wake_s wake_i, // pending enabled interrupts
    input wire logic ext_zero_level_i, // ext irq zero set to level mode
    input wire logic ext_one_level_i, // ext irq one set to level mode
    input wire slp_pkg::slp_rst_s rst_req_i, // reset sources
    input wire logic crystal_sel_i, // crystal or resonator clock option
    input wire logic conv_enabled_i, // converter enabled
    input wire logic bod_fuse_i, // brown-out fuse enabled
    input wire logic mem_we_i, // register file write
    input wire logic [4:0] mem_addr_i, // register file address
    input wire logic [7:0] mem_wdata_i, // register file write data
    output logic [7:0] mem_rdata_o, // register file read data
    output slp_pkg::slp_clk_s clk_en_o, // domain clock enables
    output logic [NPERIPH-1:0] periph_clk_en_o, // per-peripheral clock enable
    output logic [NPERIPH-1:0] periph_acc_en_o, // peripheral register access
    output logic core_run_o, // core may execute
    output logic core_reset_vec_o, // restart from reset vector
    output logic conv_start_o, // converter start pulse
    output logic conv_extended_o, // next conversion is extended
    output logic cmp_off_o, // comparator disabled
    output logic vref_en_o, // internal reference enable
    output logic bod_en_o // brown-out detector enable
);
    import slp_pkg::*;

    typedef struct packed {
        slp_state_e st;
        slp_kind_e kind;
        logic [7:0] ctrl;
        logic [7:0] stop;
        logic [7:0] cmp;
        logic [7:0] cnt;
        logic ack;
        logic [31:0] rdat;
        slp_clk_s clk;
        logic [NPERIPH-1:0] pclk;
        logic [NPERIPH-1:0] pacc;
        logic run;
        logic rvec;
        logic cstart;
        logic conv_was;
        logic ext;
        logic cmpoff;
        logic vref;
        logic bod;
    } slp_state_s;

    slp_state_s s_reg, s_next;
    logic any_rst, wake_ok, bus_req, wr_ctrl, wr_stop, wr_cmp;
    logic ext_ok;
    slp_kind_e sel_kind;

    // combine reset and wake qualifiers
    always_comb begin
        any_rst = rst_req_i.rst_ext | rst_req_i.rst_wdt | rst_req_i.rst_bod;
        // edge configs never wake outside idle
        ext_ok = (wake_i.ext_zero & ext_zero_level_i)
            | (wake_i.ext_one & ext_one_level_i); // R13
        case (s_reg.kind)
            SLP_KIND_IDLE: wake_ok = |wake_i; // R14
            SLP_KIND_NOISE: wake_ok = wake_i.conv_done | wake_i.store_ready
                | ext_ok | wake_i.pin_change; // R4
            default: wake_ok = ext_ok | wake_i.pin_change; // R6
        endcase
        sel_kind = slp_kind_e'(s_reg.ctrl[`SLP_KIND_HI:`SLP_KIND_LO]);
        bus_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
        wr_ctrl = bus_req & wb_we_i & wb_sel_i[0]
            & (wb_adr_i[`SLP_ADDR_W-1:0] == `SLP_OFF_MCU_CTRL);
        wr_stop = bus_req & wb_we_i & wb_sel_i[0]
            & (wb_adr_i[`SLP_ADDR_W-1:0] == `SLP_OFF_PERIPH_STOP);
        wr_cmp = bus_req & wb_we_i & wb_sel_i[0]
            & (wb_adr_i[`SLP_ADDR_W-1:0] == `SLP_OFF_CMP_CTRL);
    end

    // next state: bus, sleep sequencer, clock gating
    always_comb begin
        s_next = s_reg;
        s_next.ack = bus_req;
        s_next.cstart = 1'b0;
        s_next.rvec = 1'b0;
        if (wr_ctrl) begin
            s_next.ctrl = wb_dat_i[7:0] & `SLP_CTRL_WMASK;
        end
        if (wr_stop) begin
            s_next.stop = wb_dat_i[7:0] & `SLP_STOP_WMASK;
        end
        if (wr_cmp) begin
            s_next.cmp = wb_dat_i[7:0] & `SLP_CMP_WMASK;
        end
        // reads return zero for unmapped offsets
        s_next.rdat = 32'h0000_0000;
        if (bus_req & ~wb_we_i) begin
            case (wb_adr_i[`SLP_ADDR_W-1:0])
                `SLP_OFF_MCU_CTRL: s_next.rdat = {24'h00_0000, s_reg.ctrl};
                `SLP_OFF_PERIPH_STOP: s_next.rdat = {24'h00_0000, s_reg.stop};
                `SLP_OFF_CMP_CTRL: s_next.rdat = {24'h00_0000, s_reg.cmp};
                `SLP_OFF_STATUS: s_next.rdat = {27'h000_0000, s_reg.kind, s_reg.st};
                default: s_next.rdat = 32'h0000_0000;
            endcase
        end
        case (s_reg.st)
            SLP_ST_RUN: begin
                // arm clear: sleep acts as a no-operation
                if (sleep_exec_i & s_reg.ctrl[`SLP_ARM_BIT]) begin // R1 R23
                    // standby needs a crystal option, otherwise power-down
                    s_next.kind = (sel_kind == SLP_KIND_STBY && !crystal_sel_i)
                        ? SLP_KIND_PDOWN : sel_kind; // R7
                    s_next.st = SLP_ST_SLEEP;
                    s_next.cstart = conv_enabled_i
                        & ((sel_kind == SLP_KIND_IDLE) | (sel_kind == SLP_KIND_NOISE)); // R12
                end
            end
            SLP_ST_SLEEP: begin
                if (any_rst) begin
                    s_next.st = SLP_ST_RUN; // R11
                    s_next.rvec = 1'b1;
                end else if (wake_ok) begin
                    s_next.cnt = 8'h00;
                    // only power-down lost the oscillator
                    s_next.st = (s_reg.kind == SLP_KIND_PDOWN) ? SLP_ST_START : SLP_ST_HALT; // R8
                end
            end
            SLP_ST_START: begin
                s_next.cnt = s_reg.cnt + 8'h01;
                if (s_reg.cnt == 8'(START_CYCLES - 1)) begin
                    s_next.cnt = 8'h00;
                    s_next.st = SLP_ST_HALT;
                end
            end
            SLP_ST_HALT: begin
                // core stays halted four cycles once clocks run
                s_next.cnt = s_reg.cnt + 8'h01;
                if (s_reg.cnt == {4'h0, `SLP_HALT_CYCLES} - 8'h01) begin // R9
                    s_next.st = SLP_ST_RESUME;
                end
            end
            SLP_ST_RESUME: s_next.st = SLP_ST_RUN;
            default: s_next.st = SLP_ST_RUN;
        endcase
        if (any_rst & (s_reg.st != SLP_ST_RUN)) begin
            s_next.st = SLP_ST_RUN; // R11
            s_next.rvec = 1'b1;
        end
        // domain gating from the next state
        s_next.clk = '{core: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1, fast: 1'b1, osc: 1'b1};
        if (s_next.st == SLP_ST_SLEEP || s_next.st == SLP_ST_START) begin
            s_next.clk.core = 1'b0; // R2
            s_next.clk.flash = 1'b0; // R2
            case (s_next.kind)
                SLP_KIND_IDLE: ;
                SLP_KIND_NOISE: begin
                    s_next.clk.io = 1'b0; // R3
                    s_next.clk.fast = 1'b0;
                end
                SLP_KIND_PDOWN: begin
                    s_next.clk = '{default: 1'b0}; // R5
                    s_next.clk.osc = (s_next.st == SLP_ST_START);
                end
                SLP_KIND_STBY: begin
                    s_next.clk = '{default: 1'b0};
                    s_next.clk.osc = 1'b1; // R7
                end
                default: ;
            endcase
        end
        s_next.run = (s_next.st == SLP_ST_RUN) | (s_next.st == SLP_ST_RESUME);
        // per-peripheral stop: only gates when the io domain runs (the conv domain for the converter)
        for (int i = 0; i < NPERIPH; i++) begin
            s_next.pclk[i] = s_next.clk.io & ~s_next.stop[i]; // R16 R17 R18
            s_next.pacc[i] = ~s_next.stop[i]; // R16
        end
        s_next.pclk[`SLP_STOP_CONV] = ~s_next.stop[`SLP_STOP_CONV] & s_next.clk.conv; // R18
        s_next.cmpoff = s_next.cmp[`SLP_CMP_OFF_BIT]
            | ((s_next.st == SLP_ST_SLEEP || s_next.st == SLP_ST_START)
            & (s_next.kind == SLP_KIND_PDOWN || s_next.kind == SLP_KIND_STBY)); // R19
        s_next.bod = bod_fuse_i; // R22
        // reference follows its users; comparator ref use keeps it on in sleep
        s_next.vref = bod_fuse_i | conv_enabled_i
            | (~s_next.cmp[`SLP_CMP_OFF_BIT] & s_next.cmp[`SLP_CMP_REF_BIT]); // R19 R20
        // converter power cycle flags an extended conversion
        s_next.conv_was = conv_enabled_i;
        if (conv_enabled_i & ~s_reg.conv_was) begin
            s_next.ext = 1'b1; // R21
        end else if (s_reg.cstart) begin
            s_next.ext = 1'b0;
        end
    end

    // register the whole state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.ctrl <= `SLP_CTRL_RESET;
            s_reg.stop <= `SLP_STOP_RESET;
            s_reg.cmp <= `SLP_CMP_RESET;
            s_reg.clk <= '{default: 1'b1};
            s_reg.pclk <= '1;
            s_reg.pacc <= '1;
            s_reg.run <= 1'b1;
            s_reg.ext <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // retention store is never reset or cleared by sleep
    slp_retain_mem #(.DEPTH(32), .WIDTH(8)) slp_retain_mem_inst ( // R10
        .clk_i(clk_i),
        .we_i(mem_we_i & s_reg.run),
        .addr_i(mem_addr_i),
        .wdata_i(mem_wdata_i),
        .rdata_o(mem_rdata_o)
    );

    always_comb begin
        wb_ack_o = s_reg.ack;
        wb_dat_o = s_reg.rdat;
        clk_en_o = s_reg.clk;
        periph_clk_en_o = s_reg.pclk;
        periph_acc_en_o = s_reg.pacc;
        core_run_o = s_reg.run;
        core_reset_vec_o = s_reg.rvec;
        conv_start_o = s_reg.cstart;
        conv_extended_o = s_reg.ext;
        cmp_off_o = s_reg.cmpoff;
        vref_en_o = s_reg.vref;
        bod_en_o = s_reg.bod;
    end

    // standby wake: core running within six cycles
    a_stby_wake_fast: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind == SLP_KIND_STBY && wake_ok && !any_rst)
        |-> ##[1:6] core_run_o)
        else $error("standby wake too slow");
    a_halt_four: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind == SLP_KIND_IDLE && wake_ok && !any_rst)
        |=> !core_run_o [*4] ##1 core_run_o)
        else $error("halt after wake not four cycles");
    a_no_arm_nop: assert property (@(posedge clk_i) disable iff (rst_i) // R23
        (s_reg.st == SLP_ST_RUN && sleep_exec_i && !s_reg.ctrl[`SLP_ARM_BIT])
        |=> core_run_o && clk_en_o.core)
        else $error("unarmed sleep stopped core");
    a_idle_clocks: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind == SLP_KIND_IDLE)
        |-> !clk_en_o.core && clk_en_o.io && clk_en_o.osc)
        else $error("idle clock gating wrong");
    a_pdown_clocks: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind == SLP_KIND_PDOWN)
        |-> clk_en_o == '0)
        else $error("power-down left a clock running");
    a_noise_clocks: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind == SLP_KIND_NOISE)
        |-> !clk_en_o.io && clk_en_o.conv && clk_en_o.osc)
        else $error("noise mode gating wrong");
    a_reset_exit: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (s_reg.st == SLP_ST_SLEEP && any_rst) |=> core_reset_vec_o && core_run_o)
        else $error("reset in sleep not to vector");
    a_edge_no_wake: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind != SLP_KIND_IDLE && !any_rst
         && wake_i == slp_wake_s'{ext_zero: 1'b1, default: 1'b0} && !ext_zero_level_i)
        |=> s_reg.st == SLP_ST_SLEEP)
        else $error("edge interrupt woke deep sleep");
    a_cmp_forced: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind[1]) |-> cmp_off_o)
        else $error("comparator on in power-down");
    // fuse-enabled detector is never gated, asleep or awake
    a_bod_stays_on: assert property (@(posedge clk_i) disable iff (rst_i) // R22
        bod_fuse_i |=> bod_en_o)
        else $error("brown-out detector gated off");
    a_conv_start_entry: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        (s_reg.st == SLP_ST_RUN && sleep_exec_i && s_reg.ctrl[`SLP_ARM_BIT]
         && conv_enabled_i && !sel_kind[1]) |=> conv_start_o)
        else $error("no conversion on idle or noise entry");
    a_stop_blocks_access: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        periph_acc_en_o == ~s_reg.stop[NPERIPH-1:0])
        else $error("stopped peripheral still accessible");
    a_deep_periph_off: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind[1]) |-> periph_clk_en_o == '0)
        else $error("peripheral clock runs in deep sleep");
    a_stby_osc_only: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (s_reg.st == SLP_ST_SLEEP && s_reg.kind == SLP_KIND_STBY)
        |-> clk_en_o == slp_clk_s'{osc: 1'b1, default: 1'b0})
        else $error("standby gating wrong");
    a_vref_users_on: assert property (@(posedge clk_i) disable iff (rst_i) // R20
        (bod_fuse_i || conv_enabled_i) |=> vref_en_o)
        else $error("reference off while needed");
    a_vref_users_off: assert property (@(posedge clk_i) disable iff (rst_i) // R20
        (!bod_fuse_i && !conv_enabled_i && s_reg.cmp[`SLP_CMP_OFF_BIT] && !wr_cmp)
        |=> !vref_en_o)
        else $error("reference on with no user");
    a_ext_on_restart: assert property (@(posedge clk_i) disable iff (rst_i) // R21
        (conv_enabled_i && !s_reg.conv_was) |=> conv_extended_o)
        else $error("restart did not flag extended conversion");
    a_rvec_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        core_reset_vec_o |=> !core_reset_vec_o)
        else $error("reset vector pulse too long");
endmodule : slp_ctrl

//--- dv/slp_core_model.sv
// slp_core_model: behavioural processor core facing the sleep controller.
// assumes clk_i is the system clock and core_run_i comes from slp_ctrl.
`timescale 1ns/1ps
module slp_core_model (
    input wire logic clk_i, // system clock
    input wire logic core_run_i, // core may execute
    output logic sleep_exec_o, // sleep instruction pulse
    output logic mem_we_o, // register file write
    output logic [4:0] mem_addr_o, // register file address
    output logic [7:0] mem_wdata_o // register file write data
);
    initial begin
        sleep_exec_o = 1'b0;
        mem_we_o = 1'b0;
        mem_addr_o = 5'h00;
        mem_wdata_o = 8'h00;
    end

    // one-cycle sleep instruction; software armed the bit just before
    task automatic do_sleep();
        @(posedge clk_i);
        sleep_exec_o <= 1'b1;
        @(posedge clk_i);
        sleep_exec_o <= 1'b0;
    endtask : do_sleep

    // a halted core cannot store, so wait for run; data inverted after use
    task automatic mem_write(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        while (core_run_i !== 1'b1) @(posedge clk_i);
        mem_we_o <= 1'b1;
        mem_addr_o <= a;
        mem_wdata_o <= d;
        @(posedge clk_i);
        mem_we_o <= 1'b0;
        mem_wdata_o <= ~d;
    endtask : mem_write
endmodule : slp_core_model

//--- dv/slp_ctrl_tb.sv
// slp_ctrl_tb: self-checking bench for the sleep and clock gating controller.
// assumes slp_core_model plays the core; bench plays bus master and wake logic.
`timescale 1ns/1ps
`include "slp_defs.svh"
module slp_ctrl_tb;
    import slp_pkg::*;
    localparam int START = 2;
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, sleep_exec_i;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i, periph_clk_en_o, periph_acc_en_o;
    slp_wake_s wake_i;
    slp_rst_s rst_req_i;
    slp_clk_s clk_en_o;
    logic ext_zero_level_i, ext_one_level_i, crystal_sel_i, conv_enabled_i, bod_fuse_i;
    logic mem_we_i;
    logic [4:0] mem_addr_i;
    logic [7:0] mem_wdata_i, mem_rdata_o;
    logic core_run_o, core_reset_vec_o, conv_start_o, conv_extended_o;
    logic cmp_off_o, vref_en_o, bod_en_o;
    int bad_count, total_checks, cycles;

    slp_ctrl #(.START_CYCLES(START)) slp_ctrl_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .sleep_exec_i,
        .wake_i, .ext_zero_level_i, .ext_one_level_i, .rst_req_i, .crystal_sel_i,
        .conv_enabled_i, .bod_fuse_i, .mem_we_i, .mem_addr_i, .mem_wdata_i, .mem_rdata_o,
        .clk_en_o, .periph_clk_en_o, .periph_acc_en_o, .core_run_o, .core_reset_vec_o,
        .conv_start_o, .conv_extended_o, .cmp_off_o, .vref_en_o, .bod_en_o);

    slp_core_model slp_core_model_inst (.clk_i, .core_run_i(core_run_o),
        .sleep_exec_o(sleep_exec_i), .mem_we_o(mem_we_i), .mem_addr_o(mem_addr_i),
        .mem_wdata_o(mem_wdata_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // hang guard: whole run needs a few hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // classic cycle; read data taken at the ack edge, then released
    task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [7:0] d,
        input logic [3:0] sel, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= 32'(a);
        wb_dat_i <= 32'(d);
        wb_sel_i <= sel;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 8'h00, 4'h1, rd);
        check(rd, exp);
    endtask : rd_chk

    // enter mode k, try a forbidden source, then wake and time the resume
    task automatic sleep_cycle(input logic [1:0] k, input logic [7:0] bad,
        input logic [7:0] good, input logic [5:0] ce);
        int n;
        wb_xfer(1'b1, `SLP_OFF_MCU_CTRL, {2'b00, 1'b1, k, 3'b000}, 4'h1, rd);
        slp_core_model_inst.do_sleep();
        #1;
        check(core_run_o, 1'b0);
        check(clk_en_o, ce);
        check(cmp_off_o, k[1]);
        check(conv_start_o, !k[1]);
        check(bod_en_o, 1'b1);
        if (k == 2'd0) check(periph_clk_en_o, 4'hD);
        rd_chk(`SLP_OFF_STATUS, {27'h000_0000, k, 3'b001});
        if (bad != 8'h00) begin
            @(posedge clk_i);
            ext_zero_level_i <= 1'b0;
            wake_i <= bad;
            repeat (8) @(posedge clk_i);
            #1 check(core_run_o, 1'b0);
            @(posedge clk_i);
            wake_i <= '0;
            ext_zero_level_i <= 1'b1;
        end
        @(posedge clk_i);
        wake_i <= good;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (core_run_o !== 1'b1 && n < 40);
        check(32'(n), (k == 2'd2) ? 32'(5 + START) : 32'd5);
        @(posedge clk_i);
        wake_i <= '0;
    endtask : sleep_cycle

    initial begin
        rst_i = 1'b1;
        {wb_we_i, wb_cyc_i, wb_stb_i, conv_enabled_i, bod_fuse_i} = '0;
        {wb_adr_i, wb_dat_i, wb_sel_i, wake_i, rst_req_i} = '0;
        {ext_zero_level_i, ext_one_level_i, crystal_sel_i} = 3'b111;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 check(clk_en_o, 6'h3F);
        check(core_run_o, 1'b1);
        check(conv_extended_o, 1'b1);
        rd_chk(`SLP_OFF_MCU_CTRL, `SLP_CTRL_RESET);
        rd_chk(`SLP_OFF_PERIPH_STOP, `SLP_STOP_RESET);
        rd_chk(`SLP_OFF_CMP_CTRL, `SLP_CMP_RESET);
        wb_xfer(1'b1, `SLP_OFF_MCU_CTRL, 8'hFF, 4'h1, rd);
        rd_chk(`SLP_OFF_MCU_CTRL, 32'h0000_007B);
        wb_xfer(1'b1, `SLP_OFF_MCU_CTRL, 8'h00, 4'h0, rd);
        rd_chk(`SLP_OFF_MCU_CTRL, 32'h0000_007B);
        wb_xfer(1'b1, 4'h2, 8'hFF, 4'h1, rd);
        rd_chk(4'h2, 32'h0000_0000);
        wb_xfer(1'b1, `SLP_OFF_MCU_CTRL, 8'h18, 4'h1, rd);
        slp_core_model_inst.do_sleep();
        repeat (3) @(posedge clk_i);
        #1 check(core_run_o, 1'b1);
        check(clk_en_o, 6'h3F);
        $display("test registers done");
        wb_xfer(1'b1, `SLP_OFF_PERIPH_STOP, 8'h05, 4'h1, rd);
        rd_chk(`SLP_OFF_PERIPH_STOP, 32'h0000_0005);
        check(periph_clk_en_o, 4'hA);
        check(periph_acc_en_o, 4'hA);
        wb_xfer(1'b1, `SLP_OFF_PERIPH_STOP, 8'h00, 4'h1, rd);
        #1 check(periph_clk_en_o, 4'hF);
        check(periph_acc_en_o, 4'hF);
        $display("test stop bits done");
        check(vref_en_o, 1'b0);
        wb_xfer(1'b1, `SLP_OFF_CMP_CTRL, 8'h40, 4'h1, rd);
        repeat (2) @(posedge clk_i);
        #1 check(vref_en_o, 1'b1);
        wb_xfer(1'b1, `SLP_OFF_CMP_CTRL, 8'hC0, 4'h1, rd);
        repeat (2) @(posedge clk_i);
        #1 check(vref_en_o, 1'b0);
        @(posedge clk_i);
        conv_enabled_i <= 1'b1;
        bod_fuse_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 check(vref_en_o, 1'b1);
        $display("test reference done");
        // comparator back on so the forced-off check in deep sleep can trip
        wb_xfer(1'b1, `SLP_OFF_CMP_CTRL, 8'h00, 4'h1, rd);
        slp_core_model_inst.mem_write(5'h03, 8'hA5);
        wb_xfer(1'b1, `SLP_OFF_PERIPH_STOP, 8'h02, 4'h1, rd);
        for (int i = 0; i < 8; i++) sleep_cycle(2'd0, 8'h00, 8'(1 << i), 6'h0F);
        check(conv_extended_o, 1'b0);
        wb_xfer(1'b1, `SLP_OFF_PERIPH_STOP, 8'h00, 4'h1, rd);
        sleep_cycle(2'd1, 8'h01, 8'h80, 6'h05);
        sleep_cycle(2'd2, 8'h20, 8'h20, 6'h00);
        sleep_cycle(2'd3, 8'h80, 8'h08, 6'h01);
        $display("test sleep modes done");
        for (int i = 0; i < 3; i++) begin
            wb_xfer(1'b1, `SLP_OFF_MCU_CTRL, 8'h30, 4'h1, rd);
            slp_core_model_inst.do_sleep();
            rst_req_i <= slp_rst_s'(3'b001 << i);
            @(posedge clk_i);
            #1 check(core_run_o, 1'b1);
            check(core_reset_vec_o, 1'b1);
            @(posedge clk_i);
            rst_req_i <= '0;
        end
        $display("test reset in sleep done");
        @(posedge clk_i);
        conv_enabled_i <= 1'b0;
        @(posedge clk_i);
        conv_enabled_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 check(conv_extended_o, 1'b1);
        check(mem_rdata_o, 8'hA5);
        $display("test retention done");
        print_verdict();
    end
endmodule : slp_ctrl_tb
